/* rtl/ies_pkg.sv */
package ies_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS = 50;
  // internal programming time, cycles rounded up
  localparam int unsigned T_WR_NS = 5_000_000;
  localparam int unsigned WR_CYC = (T_WR_NS + CLK_NS - 1) / CLK_NS;
  // quarter of a 400 kHz scl period, least time so round up
  localparam int unsigned T_QTR_NS = 625;
  localparam logic [7:0] QTR_CYC = 8'((T_QTR_NS + CLK_NS - 1) / CLK_NS);

  // ---------------------------------------------------------------
  // memory geometry and addressing
  // ---------------------------------------------------------------
  localparam int unsigned MEM_DEPTH = 256;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] DEV_ID = 4'ha;
  localparam logic [2:0] DEV_SEL = 3'h0;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 8;

  // ---------------------------------------------------------------
  // host commands
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IES_OP_WRITE = 2'h0,
    IES_OP_CUR = 2'h1,
    IES_OP_RAND = 2'h2,
    IES_OP_POLL = 2'h3
  } ies_op_e;

endpackage : ies_pkg

/* rtl/ies_i2c_if.sv */
`timescale 1ns/1ps
interface ies_i2c_if;
  // per-party drive and enable, resolved lines
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // ---------------------------------------------------------------
  // wired-and bus, pulled high when nobody drives
  // ---------------------------------------------------------------
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

  modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport dev (output s_sda_o, s_sda_oe, input scl, sda);
endinterface : ies_i2c_if

/* rtl/ies_fifo.sv */
`timescale 1ns/1ps
module ies_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  // clock, reset, freeze
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic nempty;
    logic nfull;
  } ies_fifo_s;

  localparam ies_fifo_s Q_RST = '{nfull: 1'b1, default: '0};

  ies_fifo_s state_q;
  ies_fifo_s state_d;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  // flags are registered so the ports come from flops
  assign push = in_valid_i & state_q.nfull;
  assign pop = out_ready_i & state_q.nempty;

  // ---------------------------------------------------------------
  // pointer and count update
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (push) begin
      state_d.wp = (state_q.wp == AW'(D - 1)) ? '0 : state_q.wp + 1'b1;
    end
    if (pop) begin
      state_d.rp = (state_q.rp == AW'(D - 1)) ? '0 : state_q.rp + 1'b1;
    end
    state_d.cnt = state_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    state_d.nempty = (state_d.cnt != '0);
    state_d.nfull = (state_d.cnt != (AW + 1)'(D));
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= Q_RST;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // storage carries no reset, only flagged entries are ever read
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && push) begin
      mem[state_q.wp] <= in_data_i;
    end
  end

  assign in_ready_o = state_q.nfull;
  assign out_valid_o = state_q.nempty;
  assign out_data_o = mem[state_q.rp];
endmodule : ies_fifo

/* rtl/ies_eeprom_dev.sv */
`timescale 1ns/1ps
// Operation
// - byte write: address, word, data, each acked
// - after write stop, busy ignores all requests
// - page write takes up to 16 bytes
// - each data byte acked, low address bits increment
// - over 16 bytes wraps, overwriting earlier bytes
// - stop programs whole buffered page at once
// - master polls with start plus write address
// - busy: address unacked; idle: address acked
// - write protect makes whole array read-only
// - protected: addresses acked, first data unacked
// - reads use direction one, three forms
// - counter is last address plus one
// - counter wraps from 255 to zero
// - current read: ack, one byte, master nacks
// - random read: dummy write then restart read
// - random read returns byte at loaded address
// - master ack asks for next byte
// - read increments all address bits
// - master nack: stop sending, wait for stop
// - address upper bits 1010, last bit direction
// - reset condition refuses; running write completes
module ies_eeprom_dev #(
  parameter int unsigned WR_CYC = ies_pkg::WR_CYC,
  parameter logic [2:0] DEV_SEL = ies_pkg::DEV_SEL
) (
  // clock, reset, freeze
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // serial bus
  ies_i2c_if.dev bus,
  // protection and status
  input wire logic wp_i,
  input wire logic supv_rst_i,
  output logic busy_o
);
  localparam int unsigned PB = ies_pkg::PAGE_BYTES;
  localparam int unsigned PW = ies_pkg::PAGE_W;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ADDR = 7'b0000010,
    S_WORD = 7'b0000100,
    S_WDATA = 7'b0001000,
    S_RSTART = 7'b0010000,
    S_RDATA = 7'b0100000,
    S_WAIT = 7'b1000000
  } ies_dst_e;

  typedef struct packed {
    ies_dst_e st;
    logic scl_p;
    logic sda_p;
    logic [3:0] bitn;
    logic ackslot;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [PB-1:0][7:0] pbuf;
    logic [PB-1:0] pend;
    logic [7-PW:0] page_hi;
    logic [31:0] wr_cnt;
    logic busy;
    logic sda_oe;
  } ies_dst_s;

  localparam ies_dst_s Q_RST = '{st: S_IDLE, scl_p: 1'b1, sda_p: 1'b1, default: '0};

  ies_dst_s state_q;
  ies_dst_s state_d;
  logic [7:0] mem [ies_pkg::MEM_DEPTH];
  logic [7:0] mem_rd;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic commit;

  // ---------------------------------------------------------------
  // line events, inputs already synchronous to the clock
  // ---------------------------------------------------------------
  assign scl_rise = bus.scl & ~state_q.scl_p;
  assign scl_fall = ~bus.scl & state_q.scl_p;
  assign start_ev = bus.scl & state_q.scl_p & state_q.sda_p & ~bus.sda;
  assign stop_ev = bus.scl & state_q.scl_p & ~state_q.sda_p & bus.sda;
  assign mem_rd = mem[state_q.ptr];
  // page lands in the array as the programming time runs out
  assign commit = state_q.busy && (state_q.wr_cnt == 32'd1);

  // ---------------------------------------------------------------
  // protocol engine
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.scl_p = bus.scl;
    state_d.sda_p = bus.sda;
    // a started cycle runs to the end whatever else happens
    if (state_q.busy) begin
      if (commit) begin
        state_d.busy = 1'b0;
        state_d.pend = '0;
      end else begin
        state_d.wr_cnt = state_q.wr_cnt - 32'd1;
      end
    end
    if (supv_rst_i) begin
      // abort the transfer, drop anything not yet programming
      state_d.st = S_IDLE;
      state_d.sda_oe = 1'b0;
      if (!state_q.busy) begin
        state_d.pend = '0;
      end
    end else if (start_ev) begin
      state_d.st = S_ADDR;
      state_d.bitn = '0;
      state_d.ackslot = 1'b0;
      state_d.sda_oe = 1'b0;
    end else if (stop_ev) begin
      state_d.st = S_IDLE;
      state_d.sda_oe = 1'b0;
      if ((state_q.pend != '0) && !state_q.busy) begin
        state_d.busy = 1'b1;
        state_d.wr_cnt = WR_CYC;
      end
    end else begin
      case (state_q.st)
        S_ADDR, S_WORD, S_WDATA: begin
          if (scl_rise && !state_q.ackslot) begin
            state_d.sh = {state_q.sh[6:0], bus.sda};
            state_d.bitn = state_q.bitn + 4'h1;
          end else if (scl_fall && state_q.ackslot) begin
            // ninth clock over, let go of the line
            state_d.ackslot = 1'b0;
            state_d.bitn = '0;
            state_d.sda_oe = 1'b0;
          end else if (scl_fall && (state_q.bitn == ies_pkg::BYTE_BITS)) begin
            state_d.ackslot = 1'b1;
            if (state_q.st == S_ADDR) begin
              // busy refuses even a matching address
              if ((state_q.sh[7:1] == {ies_pkg::DEV_ID, DEV_SEL}) && !state_q.busy) begin
                state_d.sda_oe = 1'b1;
                state_d.st = (state_q.sh[0] == ies_pkg::RW_READ) ? S_RSTART : S_WORD;
              end else begin
                state_d.st = S_WAIT;
              end
            end else if (state_q.st == S_WORD) begin
              state_d.sda_oe = 1'b1;
              state_d.ptr = state_q.sh;
              state_d.st = S_WDATA;
            end else if (wp_i) begin
              state_d.st = S_WAIT;
            end else begin
              state_d.sda_oe = 1'b1;
              state_d.pbuf[state_q.ptr[PW-1:0]] = state_q.sh;
              state_d.pend[state_q.ptr[PW-1:0]] = 1'b1;
              state_d.page_hi = state_q.ptr[7:PW];
              // only the page bits move, so a long burst wraps
              state_d.ptr[PW-1:0] = state_q.ptr[PW-1:0] + 1'b1;
            end
          end
        end
        S_RSTART: begin
          // end of the address ack: fetch and present bit 7
          if (scl_fall && state_q.ackslot) begin
            state_d.ackslot = 1'b0;
            state_d.bitn = '0;
            state_d.tx = mem_rd;
            state_d.sda_oe = ~mem_rd[7];
            state_d.ptr = state_q.ptr + 8'h01;
            state_d.st = S_RDATA;
          end
        end
        S_RDATA: begin
          if (scl_rise && state_q.ackslot) begin
            if (!bus.sda) begin
              state_d.ackslot = 1'b0;
              state_d.bitn = '0;
              state_d.tx = mem_rd;
              state_d.ptr = state_q.ptr + 8'h01;
            end else begin
              state_d.st = S_WAIT;
            end
          end else if (scl_rise) begin
            state_d.bitn = state_q.bitn + 4'h1;
          end else if (scl_fall && !state_q.ackslot) begin
            if (state_q.bitn == ies_pkg::BYTE_BITS) begin
              state_d.sda_oe = 1'b0;
              state_d.ackslot = 1'b1;
            end else begin
              state_d.sda_oe = ~state_q.tx[3'(ies_pkg::BYTE_BITS - 4'h1 - state_q.bitn)];
            end
          end
        end
        S_WAIT: begin
          // line released, only start, stop or supervisor reset moves on
          state_d.sda_oe = 1'b0;
        end
        default: begin
          state_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= Q_RST;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // array: one commit of every flagged page byte
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && commit) begin
      for (int i = 0; i < PB; i++) begin
        if (state_q.pend[i]) begin
          mem[{state_q.page_hi, PW'(i)}] <= state_q.pbuf[i];
        end
      end
    end
  end

  assign busy_o = state_q.busy;
  assign bus.s_sda_oe = state_q.sda_oe;
  assign bus.s_sda_o = 1'b0;
endmodule : ies_eeprom_dev

/* rtl/ies_i2c_host.sv */
`timescale 1ns/1ps
module ies_i2c_host #(
  parameter logic [2:0] DEV_SEL = ies_pkg::DEV_SEL,
  parameter int unsigned FIFO_D = ies_pkg::FIFO_D
) (
  // clock, reset, freeze
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // serial bus
  ies_i2c_if.host bus,
  // command
  input wire logic cmd_valid_i,
  input wire ies_pkg::ies_op_e cmd_op_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_len_i,
  output logic cmd_ready_o,
  // write data
  input wire logic wr_valid_i,
  input wire logic [7:0] wr_data_i,
  output logic wr_ready_o,
  // read data
  input wire logic rd_ready_i,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // result
  output logic done_o,
  output logic nack_o
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_START = 6'b000010,
    H_TX = 6'b000100,
    H_RX = 6'b001000,
    H_WAITD = 6'b010000,
    H_STOP = 6'b100000
  } ies_hst_e;

  typedef struct packed {
    ies_hst_e st;
    ies_pkg::ies_op_e op;
    logic [1:0] step;
    logic [7:0] word;
    logic [7:0] len;
    logic [7:0] cnt;
    logic [1:0] qtr;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic scl_oe;
    logic sda_oe;
    logic push;
    logic cmd_rdy;
    logic wr_rdy;
    logic done;
    logic nack;
  } ies_hst_s;

  localparam ies_hst_s Q_RST = '{st: H_IDLE, op: ies_pkg::IES_OP_WRITE, cmd_rdy: 1'b1,
                                 default: '0};
  localparam logic [1:0] STEP_DEV = 2'h0;
  localparam logic [1:0] STEP_WORD = 2'h1;
  localparam logic [1:0] STEP_DATA = 2'h2;
  localparam logic [1:0] STEP_RDEV = 2'h3;
  localparam logic [1:0] Q_LAST = 2'h3;

  ies_hst_s state_q;
  ies_hst_s state_d;
  logic fifo_rdy;
  logic tick;
  logic hold;

  // a fresh read byte waits for room, so the bus stretches
  assign hold = (state_q.st == H_RX) && (state_q.bitn == '0) && (state_q.qtr == '0) &&
                !fifo_rdy;
  assign tick = (state_q.cnt == ies_pkg::QTR_CYC - 8'h01) && !hold;

  // ---------------------------------------------------------------
  // quarter-bit sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.push = 1'b0;
    state_d.done = 1'b0;
    if ((state_q.st != H_IDLE) && (state_q.st != H_WAITD) && !hold) begin
      state_d.cnt = tick ? '0 : state_q.cnt + 8'h01;
    end
    case (state_q.st)
      H_IDLE: begin
        if (cmd_valid_i && state_q.cmd_rdy) begin
          state_d.cmd_rdy = 1'b0;
          state_d.op = cmd_op_i;
          state_d.word = cmd_addr_i;
          state_d.len = cmd_len_i;
          state_d.nack = 1'b0;
          state_d.step = STEP_DEV;
          state_d.sh = {ies_pkg::DEV_ID, DEV_SEL,
                        (cmd_op_i == ies_pkg::IES_OP_CUR) ? ies_pkg::RW_READ : ies_pkg::RW_WRITE};
          state_d.st = H_START;
          state_d.qtr = '0;
          state_d.cnt = '0;
        end
      end
      H_START, H_STOP: begin
        if (tick) begin
          state_d.qtr = state_q.qtr + 2'h1;
          case (state_q.qtr)
            2'h0: state_d.sda_oe = (state_q.st == H_STOP);
            2'h1: state_d.scl_oe = 1'b0;
            2'h2: state_d.sda_oe = (state_q.st == H_START);
            default: state_d.scl_oe = (state_q.st == H_START);
          endcase
          if (state_q.qtr == Q_LAST) begin
            state_d.bitn = '0;
            if (state_q.st == H_START) begin
              state_d.st = H_TX;
            end else begin
              state_d.st = H_IDLE;
              state_d.done = 1'b1;
              state_d.cmd_rdy = 1'b1;
            end
          end
        end
      end
      H_TX, H_RX: begin
        if (tick) begin
          state_d.qtr = state_q.qtr + 2'h1;
          case (state_q.qtr)
            2'h0: begin
              if (state_q.st == H_TX) begin
                state_d.sda_oe = (state_q.bitn != ies_pkg::BYTE_BITS) && !state_q.sh[7];
              end else begin
                // ack every byte but the last one asked for
                state_d.sda_oe = (state_q.bitn == ies_pkg::BYTE_BITS) && (state_q.len != 8'h01);
              end
            end
            2'h1: state_d.scl_oe = 1'b0;
            2'h2: begin
              if (state_q.bitn == ies_pkg::BYTE_BITS) begin
                state_d.nack = (state_q.st == H_TX) && bus.sda;
              end else if (state_q.st == H_TX) begin
                state_d.sh = {state_q.sh[6:0], 1'b0};
              end else begin
                state_d.sh = {state_q.sh[6:0], bus.sda};
              end
            end
            default: begin
              state_d.scl_oe = 1'b1;
              state_d.bitn = state_q.bitn + 4'h1;
              if ((state_q.st == H_RX) && (state_q.bitn == ies_pkg::BYTE_BITS - 4'h1)) begin
                state_d.push = 1'b1;
              end
            end
          endcase
          if ((state_q.qtr == Q_LAST) && (state_q.bitn == ies_pkg::BYTE_BITS)) begin
            state_d.bitn = '0;
            state_d.sda_oe = 1'b0;
            state_d.st = H_STOP;
            if (state_q.st == H_RX) begin
              state_d.len = state_q.len - 8'h01;
              if (state_q.len != 8'h01) begin
                state_d.st = H_RX;
              end
            end else if (state_d.nack || (state_q.op == ies_pkg::IES_OP_POLL)) begin
              state_d.st = H_STOP;
            end else if ((state_q.step == STEP_RDEV) || (state_q.op == ies_pkg::IES_OP_CUR)) begin
              state_d.st = H_RX;
            end else if (state_q.step == STEP_DEV) begin
              state_d.step = STEP_WORD;
              state_d.sh = state_q.word;
              state_d.st = H_TX;
            end else if (state_q.op == ies_pkg::IES_OP_RAND) begin
              // repeated start for the read half
              state_d.step = STEP_RDEV;
              state_d.sh = {ies_pkg::DEV_ID, DEV_SEL, ies_pkg::RW_READ};
              state_d.st = H_START;
            end else begin
              if (state_q.step == STEP_DATA) begin
                state_d.len = state_q.len - 8'h01;
              end
              state_d.step = STEP_DATA;
              if ((state_q.step != STEP_DATA) || (state_q.len != 8'h01)) begin
                state_d.st = H_WAITD;
                state_d.wr_rdy = 1'b1;
              end
            end
          end
        end
      end
      H_WAITD: begin
        // scl stays low while the user supplies the byte
        if (wr_valid_i && state_q.wr_rdy) begin
          state_d.wr_rdy = 1'b0;
          state_d.sh = wr_data_i;
          state_d.st = H_TX;
          state_d.qtr = '0;
          state_d.cnt = '0;
        end
      end
      default: begin
        state_d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= Q_RST;
    end else if (ce_i) begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // read data buffer
  // ---------------------------------------------------------------
  ies_fifo #(
    .W(ies_pkg::FIFO_W),
    .D(FIFO_D)
  ) u_rd_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .in_valid_i(state_q.push),
    .in_data_i(state_q.sh),
    .in_ready_o(fifo_rdy),
    .out_ready_i(rd_ready_i),
    .out_valid_o(rd_valid_o),
    .out_data_o(rd_data_o)
  );

  assign bus.m_scl_oe = state_q.scl_oe;
  assign bus.m_sda_oe = state_q.sda_oe;
  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign cmd_ready_o = state_q.cmd_rdy;
  assign wr_ready_o = state_q.wr_rdy;
  assign done_o = state_q.done;
  assign nack_o = state_q.nack;
endmodule : ies_i2c_host

/* verification/ies_props.sv */
`timescale 1ns/1ps
module ies_props #(
  parameter int unsigned WR_CYC = 20
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // bus lines and device status
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe,
  input wire logic busy_o,
  input wire logic wp_i
);
  // ---------------------------------------------------------------
  // busy length counter
  // ---------------------------------------------------------------
  logic [31:0] cnt_q;

  // wide so a full-length programming time never overflows
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= busy_o ? cnt_q + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_busy_quiet; busy_o |-> !s_sda_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("device drove sda while busy");
  property p_busy_cause; $rose(busy_o) |-> scl && sda; endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("programming began without a stop");
  property p_busy_exact; $fell(busy_o) |-> cnt_q == WR_CYC; endproperty
  a_busy_exact: assert property (p_busy_exact)
    else $error("programming time wrong");
  property p_busy_cap; busy_o |-> cnt_q < WR_CYC; endproperty
  a_busy_cap: assert property (p_busy_cap)
    else $error("programming ran too long");
  property p_wp_hold; wp_i && $past(wp_i) |-> !$rose(busy_o); endproperty
  a_wp_hold: assert property (p_wp_hold)
    else $error("programming under protection");
  property p_oe_low; $changed(s_sda_oe) |-> !scl; endproperty
  a_oe_low: assert property (p_oe_low)
    else $error("device moved sda while scl high");
  property p_ack_setup; $rose(s_sda_oe) |-> (!scl) [*2]; endproperty
  a_ack_setup: assert property (p_ack_setup)
    else $error("device drive too late in low phase");
  property p_start_free; scl && $fell(sda) |-> !s_sda_oe; endproperty
  a_start_free: assert property (p_start_free)
    else $error("device held sda at start");

  // main scenarios reached
  c_prog: cover property ($fell(busy_o));
  c_drive: cover property ($rose(s_sda_oe));
  c_wp: cover property (wp_i && $rose(s_sda_oe));
endmodule : ies_props

/* verification/tb_i2c_eeprom_slave_ops.sv */
`timescale 1ns/1ps
module tb_i2c_eeprom_slave_ops;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  // shortened programming time, still longer than one poll
  localparam int unsigned WRC = 2000;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wp_i = 1'b0;
  // supervisor reset, driven so the abort and finish paths are exercised
  logic supv_rst_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  ies_pkg::ies_op_e cmd_op_i = ies_pkg::IES_OP_POLL;
  logic [7:0] cmd_addr_i = 8'h00;
  logic [7:0] cmd_len_i = 8'h01;
  logic wr_valid_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic rd_ready_i = 1'b1;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, nack_o, busy_o;
  logic [7:0] rd_data_o;
  logic [7:0] mem [256];
  logic [7:0] wq [32];
  logic [7:0] got [$];
  int failures = 0;
  int tests_run = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  ies_i2c_if ies_i2c_if_i ();
  ies_eeprom_dev #(.WR_CYC(WRC)) ies_eeprom_dev_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .ce_i(1'b1), .bus(ies_i2c_if_i), .wp_i(wp_i), .supv_rst_i(supv_rst_i), .busy_o(busy_o));
  ies_i2c_host ies_i2c_host_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .bus(ies_i2c_if_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i), .cmd_ready_o(cmd_ready_o),
    .wr_valid_i(wr_valid_i), .wr_data_i(wr_data_i), .wr_ready_o(wr_ready_o),
    .rd_ready_i(rd_ready_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .done_o(done_o), .nack_o(nack_o));
  ies_props #(.WR_CYC(WRC)) ies_props_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .scl(ies_i2c_if_i.scl), .sda(ies_i2c_if_i.sda), .s_sda_oe(ies_i2c_if_i.s_sda_oe),
    .busy_o(busy_o), .wp_i(wp_i));

  // ---------------------------------------------------------------
  // compare and closing tasks
  // ---------------------------------------------------------------
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: byte %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("Error %0t: nack flag %b expected %b", $time, g, e);
    end
  endtask : chk1

  task automatic conclude();
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // host command driver
  // ---------------------------------------------------------------
  // sample at the falling edge, drive at the rising edge
  task automatic run(input ies_pkg::ies_op_e op, input logic [7:0] a, input logic [7:0] n,
    input bit stall);
    int k;
    int wi;
    bit dn;
    bit w;
    got.delete();
    wi = 0;
    dn = 1'b0;
    cmd_op_i <= op;
    cmd_addr_i <= a;
    cmd_len_i <= n;
    cmd_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    for (k = 0; k < 30000 && !(dn && rd_valid_o !== 1'b1); k++) begin
      @(negedge ref_clk_i);
      dn = dn || (done_o === 1'b1);
      if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
        got.push_back(rd_data_o);
      end
      w = wr_ready_o === 1'b1 && wr_valid_i === 1'b0 && wi < int'(n);
      @(posedge ref_clk_i);
      // a stalled drain lets the fifo fill and the host stretch scl
      rd_ready_i <= !stall || k > 6000;
      wr_valid_i <= w;
      if (w) begin
        wr_data_i <= wq[wi];
        wi++;
      end
    end
    if (!dn) begin
      failures++;
      $display("Error %0t: command never finished", $time);
      conclude();
    end
  endtask : run

  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] b);
    for (int i = 0; i < n; i++) begin
      wq[i] = b + 8'(i);
      // the page wraps on the low four address bits only
      if (wp_i === 1'b0) begin
        mem[{a[7:4], a[3:0] + 4'(i)}] = b + 8'(i);
      end
    end
    run(ies_pkg::IES_OP_WRITE, a, 8'(n), 1'b0);
    chk1(nack_o, wp_i);
  endtask : wr

  task automatic settle();
    int p;
    run(ies_pkg::IES_OP_POLL, 8'h00, 8'h01, 1'b0);
    chk1(nack_o, 1'b1);
    for (p = 0; p < 20 && nack_o !== 1'b0; p++) begin
      run(ies_pkg::IES_OP_POLL, 8'h00, 8'h01, 1'b0);
    end
    chk1(nack_o, 1'b0);
  endtask : settle

  task automatic rd(input ies_pkg::ies_op_e op, input logic [7:0] a, input logic [7:0] n,
    input bit s);
    run(op, a, n, s);
    for (int i = 0; i < int'(n); i++) begin
      chk8(got[i], mem[8'(a + 8'(i))]);
    end
  endtask : rd

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    run(ies_pkg::IES_OP_POLL, 8'h00, 8'h01, 1'b0);
    chk1(nack_o, 1'b0);
    wr(8'h00, 4, 8'h11);
    settle();
    wr(8'hfe, 2, 8'hc0);
    settle();
    wr(8'h3e, 18, 8'h40);
    settle();
    rd(ies_pkg::IES_OP_RAND, 8'hff, 8'h04, 1'b0);
    rd(ies_pkg::IES_OP_CUR, 8'h03, 8'h01, 1'b0);
    rd(ies_pkg::IES_OP_RAND, 8'h30, 8'h10, 1'b1);
    // supervisor reset during programming: all refused, cycle still lands
    wr(8'h05, 1, 8'h77);
    supv_rst_i <= 1'b1;
    repeat (5) begin
      run(ies_pkg::IES_OP_POLL, 8'h00, 8'h01, 1'b0);
      chk1(nack_o, 1'b1);
    end
    supv_rst_i <= 1'b0;
    run(ies_pkg::IES_OP_POLL, 8'h00, 8'h01, 1'b0);
    chk1(nack_o, 1'b0);
    rd(ies_pkg::IES_OP_RAND, 8'h05, 8'h01, 1'b0);
    wp_i <= 1'b1;
    @(posedge ref_clk_i);
    wr(8'h01, 1, 8'h99);
    wp_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(ies_pkg::IES_OP_RAND, 8'h01, 8'h01, 1'b0);
    conclude();
  end
endmodule : tb_i2c_eeprom_slave_ops
